// ==== rtl/scg_pkg.sv ====
// Constants, types and helpers for the sleep-mode clock gating block.
// Assumes one system clock; all offsets are byte addresses on the
// 12-bit register port.
package scg_pkg;

   // Register port geometry
   localparam int unsigned SCG_AW = 12;
   localparam int unsigned SCG_DW = 32;

   // Register offsets
   localparam logic [11:0] SCG_OFS_RUN_GATE  = 12'h100;
   localparam logic [11:0] SCG_OFS_SLP_GATE  = 12'h110;
   localparam logic [11:0] SCG_OFS_DEEP_GATE = 12'h120;
   localparam logic [11:0] SCG_OFS_RUN_CFG   = 12'h130;
   localparam logic [11:0] SCG_OFS_INT_STAT  = 12'h140;
   localparam logic [11:0] SCG_OFS_INT_MASK  = 12'h144;
   localparam logic [11:0] SCG_OFS_RST_INFO  = 12'h148;
   localparam logic [11:0] SCG_OFS_MODE_STAT = 12'h14C;

   // Gate word field positions
   localparam int unsigned SCG_BIT_ADC0  = 16;
   localparam int unsigned SCG_BIT_WDOG  = 3;
   localparam int unsigned SCG_RATE_LSB  = 8;
   localparam int unsigned SCG_RATE_MSB  = 9;

   // Writable bits of a gate word; everything else reads zero
   localparam logic [31:0] SCG_GATE_WMASK = 32'h0001_0308;
   // Reset value reported for the gate word layout
   localparam logic [31:0] SCG_GATE_RESET = 32'h0000_0040;
   // Value actually held after reset: documented word, writable bits
   localparam logic [31:0] SCG_GATE_INIT  = SCG_GATE_RESET & SCG_GATE_WMASK;

   // Converter sample rate codes
   localparam logic [1:0] SCG_RATE_125K = 2'h0;
   localparam logic [1:0] SCG_RATE_250K = 2'h1;
   localparam logic [1:0] SCG_RATE_500K = 2'h2;
   localparam logic [1:0] SCG_RATE_1M   = 2'h3;

   // Run configuration word
   localparam int unsigned SCG_CFG_AUTO_BIT = 0;
   localparam logic [31:0] SCG_CFG_WMASK    = 32'h0000_0001;
   localparam logic [31:0] SCG_CFG_INIT     = 32'h0000_0000;

   // Interrupt status bits
   localparam int unsigned SCG_IRQ_W          = 3;
   localparam int unsigned SCG_IRQ_ADC_FAULT  = 0;
   localparam int unsigned SCG_IRQ_WDOG_FAULT = 1;
   localparam int unsigned SCG_IRQ_MODE_CHG   = 2;
   localparam logic [2:0]  SCG_IRQ_INIT       = 3'h0;

   // Gated units
   localparam int unsigned SCG_NUM_UNITS = 2;
   localparam int unsigned SCG_UNIT_ADC0 = 0;
   localparam int unsigned SCG_UNIT_WDOG = 1;

   // Power modes
   typedef enum logic [1:0] {
      SCG_MODE_RUN,
      SCG_MODE_SLEEP,
      SCG_MODE_DEEP
   } scg_mode_t;

   // Unit enables held in a gate word, one bit per unit
   function automatic logic [1:0] scg_gate_bits(input logic [31:0] word);
      logic [1:0] bits;
      bits = 2'h0;
      bits[SCG_UNIT_ADC0] = word[SCG_BIT_ADC0];
      bits[SCG_UNIT_WDOG] = word[SCG_BIT_WDOG];
      return bits;
   endfunction : scg_gate_bits

endpackage : scg_pkg

// ==== rtl/scg_unit_if.sv ====
// Bundle between the gating controller and its access checker.
// Assumes all signals are on the system clock.
`timescale 1ns/100ps
interface scg_unit_if #(parameter int unsigned N = 2);
   logic [N-1:0] clk_en;   // Current unit clock enables
   logic [N-1:0] acc_req;  // Access aimed at a unit
   logic [N-1:0] fault;    // Access hit a gated unit
   logic [N-1:0] done;     // Access completed normally

   modport ctrl (output clk_en, output acc_req, input fault, input done);
   modport chk  (input clk_en, input acc_req, output fault, output done);
endinterface : scg_unit_if

// ==== rtl/scg_clk_gate.sv ====
// Latch-based glitch-free clock gate for one unit.
// Assumes en comes from a flop on the same clock.
`timescale 1ns/100ps
module scg_clk_gate (
   // Clock
   input  wire logic core_clk,
   // Control
   input  wire logic en,
   // Gated clock
   output wire logic gclk
);

   logic en_lat;

   // Enable only moves while the clock is low
   always_latch
   begin
      if (!core_clk)
      begin
         en_lat <= en;
      end
   end

   assign gclk = core_clk & en_lat;

endmodule : scg_clk_gate

// ==== rtl/scg_acc_chk.sv ====
// Answers each unit access with a fault or a normal completion.
// Assumes accesses are one-cycle pulses on the system clock.
`timescale 1ns/100ps
module scg_acc_chk
   import scg_pkg::*;
#(
   parameter int unsigned N = SCG_NUM_UNITS
) (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic srst,
   // Unit bundle
   scg_unit_if.chk   u
);

   logic [N-1:0] fault_ff;
   logic [N-1:0] done_ff;

   // One answer per access, one cycle after it
   genvar gi;
   generate
      for (gi = 0; gi < N; gi++)
      begin : g_unit
         always_ff @(posedge core_clk)
         begin
            if (srst)
            begin
               fault_ff[gi] <= 1'b0;
               done_ff[gi]  <= 1'b0;
            end
            else
            begin
               fault_ff[gi] <= u.acc_req[gi] & ~u.clk_en[gi];
               done_ff[gi]  <= u.acc_req[gi] &  u.clk_en[gi];
            end
         end
      end
   endgenerate

   assign u.fault = fault_ff;
   assign u.done  = done_ff;

endmodule : scg_acc_chk

// ==== rtl/scg_ctrl.sv ====
// Clock gating control: run, sleep and deep-sleep gate words, mode
// tracking, unit clock gates, access fault answers and interrupt.
// Assumes a single system clock, synchronous active-high reset, and
// mode requests and unit accesses from logic on the same clock.
//
// Functional notes
// - Each gate bit enables one unit's clock: one runs it, zero stops it.
// - An access to a unit whose clock is gated off is answered with a fault.
// - After reset all gate bits are zero so every unit starts unclocked.
// - The sleep word governs only Sleep; Run uses the run word, Deep the deep word or, without automatic gating, the run word.
// - Sleep-mode words apply only while automatic gating is selected.
// - Bit 16 is the read-write converter 0 clock gate, reset zero.
// - Bit 3 is the read-write watchdog clock gate, reset zero.
// - Bits 9:8 select the converter sample rate, 125K up to 1M, reset zero.
// - Bits 31:17, 15:10, 7:4, 2:0 read zero; software preserves them.
// - The sleep word sits at 0x110; its reset value 0x40 is reported.
`timescale 1ns/100ps
module scg_ctrl
   import scg_pkg::*;
(
   // Clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 srst,
   // Register port
   input  wire logic [SCG_AW-1:0]    reg_addr,
   input  wire logic [SCG_DW-1:0]    reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output      logic [SCG_DW-1:0]    reg_rdata,
   // Power mode requests
   input  wire logic                 sleep_req,
   input  wire logic                 deep_sleep_req,
   // Unit accesses
   input  wire logic [1:0]           unit_acc_req,
   output      logic [1:0]           unit_acc_fault,
   output      logic [1:0]           unit_acc_done,
   // Unit clocks
   output      logic [1:0]           unit_clk_en,
   output      logic [1:0]           unit_gclk,
   output      logic [1:0]           converter_sample_rate,
   // Interrupt
   output      logic                 irq
);

   // Gate words and configuration
   logic [31:0]          run_clock_gate_ctrl0_ff;
   logic [31:0]          sleep_clock_gate_ctrl0_ff;
   logic [31:0]          deep_sleep_clock_gate_ctrl0_ff;
   logic [31:0]          run_clock_configuration_ff;
   logic                 auto_gating_select;

   // Mode tracking
   scg_mode_t            mode_ff;
   scg_mode_t            nxt_mode;

   // Selected word and derived controls
   logic [31:0]          sel_word;
   logic [1:0]           clk_en_ff;
   logic [1:0]           nxt_clk_en;
   logic [1:0]           rate_ff;
   logic [1:0]           nxt_rate;

   // Interrupt state
   logic [SCG_IRQ_W-1:0] int_stat_ff;
   logic [SCG_IRQ_W-1:0] int_mask_ff;
   logic [SCG_IRQ_W-1:0] int_evt;
   logic [SCG_IRQ_W-1:0] int_clr;

   // Read path
   logic [31:0]          rdata_ff;
   logic [31:0]          nxt_rdata;

   // Write and status-read decode strobes
   logic                 wr_run;
   logic                 wr_slp;
   logic                 wr_deep;
   logic                 wr_cfg;
   logic                 wr_mask;
   logic                 rd_stat;

   // Unit bundle towards the access checker
   scg_unit_if #(.N(SCG_NUM_UNITS)) unit_bus ();

   // Write strobes per register
   always_comb
   begin
      wr_run  = 1'b0;
      wr_slp  = 1'b0;
      wr_deep = 1'b0;
      wr_cfg  = 1'b0;
      wr_mask = 1'b0;
      if (reg_wr && reg_addr == SCG_OFS_RUN_GATE)
      begin
         wr_run = 1'b1;
      end
      else if (reg_wr && reg_addr == SCG_OFS_SLP_GATE)
      begin
         wr_slp = 1'b1;
      end
      else if (reg_wr && reg_addr == SCG_OFS_DEEP_GATE)
      begin
         wr_deep = 1'b1;
      end
      else if (reg_wr && reg_addr == SCG_OFS_RUN_CFG)
      begin
         wr_cfg = 1'b1;
      end
      else if (reg_wr && reg_addr == SCG_OFS_INT_MASK)
      begin
         wr_mask = 1'b1;
      end
   end

   // Status read strobe, clears what it returns
   assign rd_stat = reg_rd && (reg_addr == SCG_OFS_INT_STAT);

   // Run-mode gate word
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         run_clock_gate_ctrl0_ff <= SCG_GATE_INIT;
      end
      else if (wr_run)
      begin
         run_clock_gate_ctrl0_ff <= reg_wdata & SCG_GATE_WMASK;
      end
   end

   // Sleep-mode gate word: converter gate, rate field, watchdog gate
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         sleep_clock_gate_ctrl0_ff <= SCG_GATE_INIT;
      end
      else if (wr_slp)
      begin
         // Only bits 16, 9:8 and 3 hold; the rest stay zero
         sleep_clock_gate_ctrl0_ff <=
            reg_wdata & SCG_GATE_WMASK;
      end
   end

   // Deep-sleep gate word
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         deep_sleep_clock_gate_ctrl0_ff <= SCG_GATE_INIT;
      end
      else if (wr_deep)
      begin
         deep_sleep_clock_gate_ctrl0_ff <= reg_wdata & SCG_GATE_WMASK;
      end
   end

   // Run configuration, holds the automatic gating select
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         run_clock_configuration_ff <= SCG_CFG_INIT;
      end
      else if (wr_cfg)
      begin
         run_clock_configuration_ff <= reg_wdata & SCG_CFG_WMASK;
      end
   end

   assign auto_gating_select = run_clock_configuration_ff[SCG_CFG_AUTO_BIT];

   // Mode follows the requests, deep sleep taking priority
   always_comb
   begin
      if (deep_sleep_req)
      begin
         nxt_mode = SCG_MODE_DEEP;
      end
      else if (sleep_req)
      begin
         nxt_mode = SCG_MODE_SLEEP;
      end
      else
      begin
         nxt_mode = SCG_MODE_RUN;
      end
   end

   // Current power mode
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         mode_ff <= SCG_MODE_RUN;
      end
      else
      begin
         mode_ff <= nxt_mode;
      end
   end

   // Choose the gate word that governs the current mode
   always_comb
   begin
      case (mode_ff)
         SCG_MODE_SLEEP:
         begin
            // Sleep word only with automatic gating selected
            sel_word = auto_gating_select ? sleep_clock_gate_ctrl0_ff
                                          : run_clock_gate_ctrl0_ff;
         end
         SCG_MODE_DEEP:
         begin
            sel_word = auto_gating_select ? deep_sleep_clock_gate_ctrl0_ff
                                          : run_clock_gate_ctrl0_ff;
         end
         default:
         begin
            sel_word = run_clock_gate_ctrl0_ff;
         end
      endcase
   end

   // Enables and rate taken from the selected word
   always_comb
   begin
      nxt_clk_en = scg_gate_bits(sel_word);
      nxt_rate   = sel_word[SCG_RATE_MSB:SCG_RATE_LSB];
   end

   // Registered unit enables, so the gates see clean levels
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         clk_en_ff <= scg_gate_bits(SCG_GATE_INIT);
      end
      else
      begin
         clk_en_ff <= nxt_clk_en;
      end
   end

   // Registered converter sample rate
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         rate_ff <= SCG_RATE_125K;
      end
      else
      begin
         rate_ff <= nxt_rate;
      end
   end

   // One glitch-free gate per unit
   genvar gi;
   generate
      for (gi = 0; gi < SCG_NUM_UNITS; gi++)
      begin : g_gate
         scg_clk_gate u_gate (
            .core_clk (core_clk),
            .en       (clk_en_ff[gi]),
            .gclk     (unit_gclk[gi])
         );
      end
   endgenerate

   // Bundle to the access checker
   assign unit_bus.clk_en  = clk_en_ff;
   assign unit_bus.acc_req = unit_acc_req;

   // Faults for accesses to gated units
   scg_acc_chk #(
      .N (SCG_NUM_UNITS)
   ) u_chk (
      .core_clk (core_clk),
      .srst     (srst),
      .u        (unit_bus.chk)
   );

   // Events: access faults per unit and any mode change
   always_comb
   begin
      int_evt = '0;
      int_evt[SCG_IRQ_ADC_FAULT]  = unit_bus.fault[SCG_UNIT_ADC0];
      int_evt[SCG_IRQ_WDOG_FAULT] = unit_bus.fault[SCG_UNIT_WDOG];
      int_evt[SCG_IRQ_MODE_CHG]   = (nxt_mode != mode_ff);
   end

   assign int_clr = rd_stat ? int_stat_ff : '0;

   // Sticky status; a new event wins over a read clear
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         int_stat_ff <= SCG_IRQ_INIT;
      end
      else
      begin
         int_stat_ff <= (int_stat_ff & ~int_clr) | int_evt;
      end
   end

   // Interrupt mask, same layout as status
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         int_mask_ff <= SCG_IRQ_INIT;
      end
      else if (wr_mask)
      begin
         int_mask_ff <= reg_wdata[SCG_IRQ_W-1:0];
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb
   begin
      nxt_rdata = 32'h0000_0000;
      if (reg_addr == SCG_OFS_RUN_GATE)
      begin
         nxt_rdata = run_clock_gate_ctrl0_ff;
      end
      else if (reg_addr == SCG_OFS_SLP_GATE)
      begin
         nxt_rdata = sleep_clock_gate_ctrl0_ff & SCG_GATE_WMASK;
      end
      else if (reg_addr == SCG_OFS_DEEP_GATE)
      begin
         nxt_rdata = deep_sleep_clock_gate_ctrl0_ff;
      end
      else if (reg_addr == SCG_OFS_RUN_CFG)
      begin
         nxt_rdata = run_clock_configuration_ff;
      end
      else if (reg_addr == SCG_OFS_INT_STAT)
      begin
         nxt_rdata = {29'h0, int_stat_ff};
      end
      else if (reg_addr == SCG_OFS_INT_MASK)
      begin
         nxt_rdata = {29'h0, int_mask_ff};
      end
      else if (reg_addr == SCG_OFS_RST_INFO)
      begin
         nxt_rdata = SCG_GATE_RESET;
      end
      else if (reg_addr == SCG_OFS_MODE_STAT)
      begin
         nxt_rdata = {24'h0, rate_ff, clk_en_ff, 2'h0, mode_ff};
      end
   end

   // Read data stands for the one cycle after the strobe
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         rdata_ff <= 32'h0000_0000;
      end
      else if (reg_rd)
      begin
         rdata_ff <= nxt_rdata;
      end
      else
      begin
         rdata_ff <= 32'h0000_0000;
      end
   end

   // Outputs
   assign reg_rdata             = rdata_ff;
   assign unit_clk_en           = clk_en_ff;
   assign converter_sample_rate = rate_ff;
   assign unit_acc_fault        = unit_bus.fault;
   assign unit_acc_done         = unit_bus.done;
   assign irq                   = |(int_stat_ff & int_mask_ff); // Level

endmodule : scg_ctrl

// ==== test/scg_ctrl_asserts.sv ====
// Port checker for the sleep-mode clock gating controller.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module scg_ctrl_asserts
   import scg_pkg::*;
(
   // Clock and reset
   input wire logic              core_clk,
   input wire logic              srst,
   // Register port
   input wire logic [SCG_AW-1:0] reg_addr,
   input wire logic [SCG_DW-1:0] reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [SCG_DW-1:0] reg_rdata,
   // Modes and units
   input wire logic              sleep_req,
   input wire logic              deep_sleep_req,
   input wire logic [1:0]        unit_acc_req,
   input wire logic [1:0]        unit_acc_fault,
   input wire logic [1:0]        unit_acc_done,
   input wire logic [1:0]        unit_clk_en,
   input wire logic [1:0]        unit_gclk,
   input wire logic [1:0]        converter_sample_rate,
   input wire logic              irq
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   // Sleep word written, then read at once
   sequence s_wr_rd;
      reg_wr && reg_addr == SCG_OFS_SLP_GATE
      ##1 reg_rd && reg_addr == SCG_OFS_SLP_GATE;
   endsequence

   property p_fault;
      |unit_acc_req |=>
         unit_acc_fault == $past(unit_acc_req & ~unit_clk_en);
   endproperty
   property p_done;
      |unit_acc_req |=>
         unit_acc_done == $past(unit_acc_req & unit_clk_en);
   endproperty
   property p_noreq;
      !(|unit_acc_req) |=> unit_acc_fault == 2'h0 && unit_acc_done == 2'h0;
   endproperty
   property p_idle;
      !reg_rd |=> reg_rdata == 32'h0;
   endproperty
   property p_unmap;
      reg_rd && reg_addr == 12'h150 |=> reg_rdata == 32'h0;
   endproperty
   property p_resv;
      reg_rd && reg_addr == SCG_OFS_SLP_GATE |=>
         (reg_rdata & ~SCG_GATE_WMASK) == 32'h0;
   endproperty
   property p_info;
      reg_rd && reg_addr == SCG_OFS_RST_INFO |=> reg_rdata == 32'h40;
   endproperty
   property p_wrrd;
      s_wr_rd |=> reg_rdata == ($past(reg_wdata, 2) & SCG_GATE_WMASK);
   endproperty

   a_fault: assert property (p_fault) else $error("fault answer wrong");
   a_done:  assert property (p_done) else $error("done answer wrong");
   a_noreq: assert property (p_noreq) else $error("stray answer");
   a_idle:  assert property (p_idle) else $error("read data not idle");
   a_unmap: assert property (p_unmap) else $error("unmapped read set");
   a_resv:  assert property (p_resv) else $error("reserved bits set");
   a_info:  assert property (p_info) else $error("reset info wrong");
   a_wrrd:  assert property (p_wrrd) else $error("readback wrong");

   // Gated clock high phase carries the enable of the low phase before it
   property p_gclk;
      @(negedge core_clk) unit_gclk == $past(unit_clk_en);
   endproperty
   a_gclk:  assert property (p_gclk) else $error("gated clock wrong");
endmodule : scg_ctrl_asserts

bind scg_ctrl scg_ctrl_asserts u_asserts (
   .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .sleep_req(sleep_req),
   .deep_sleep_req(deep_sleep_req), .unit_acc_req(unit_acc_req),
   .unit_acc_fault(unit_acc_fault), .unit_acc_done(unit_acc_done),
   .unit_clk_en(unit_clk_en), .unit_gclk(unit_gclk),
   .converter_sample_rate(converter_sample_rate), .irq(irq)
);

// ==== test/scg_ctrl_bench.sv ====
// Self-checking bench for the sleep-mode clock gating controller.
// Assumes scg_pkg, the design and the checker are compiled first.
`timescale 1ns/100ps
`define CHK(g, e) \
   begin \
      total_checks++; \
      if ((g) !== (e)) \
      begin \
         bad_count++; \
         $display("ERROR t=%0t got %h exp %h", $time, g, e); \
      end \
   end
module scg_ctrl_bench
   import scg_pkg::*;
;
   logic              core_clk, srst, reg_wr, reg_rd, irq;
   logic              sleep_req, deep_sleep_req;
   logic [SCG_AW-1:0] reg_addr;
   logic [SCG_DW-1:0] reg_wdata, reg_rdata;
   logic [1:0]        unit_acc_req, unit_acc_fault, unit_acc_done;
   logic [1:0]        unit_clk_en, unit_gclk, converter_sample_rate;
   int                bad_count, total_checks, k;

   scg_ctrl dut_u (
      .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .sleep_req(sleep_req),
      .deep_sleep_req(deep_sleep_req), .unit_acc_req(unit_acc_req),
      .unit_acc_fault(unit_acc_fault), .unit_acc_done(unit_acc_done),
      .unit_clk_en(unit_clk_en), .unit_gclk(unit_gclk),
      .converter_sample_rate(converter_sample_rate), .irq(irq)
   );

   // 100 MHz clock
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick

   // One-cycle register write
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask : wr

   // One-cycle read, data checked in the next cycle
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask : rd

   // Write then read back with no gap between the strobes
   task automatic wr_rd(input logic [11:0] a, input logic [31:0] d,
                        input logic [31:0] e);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b1;
      @(posedge core_clk);
      reg_rd    <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask : wr_rd

   // Unit access pulse, answer one cycle later
   task automatic acc(input logic [1:0] r, input logic [1:0] f);
      @(posedge core_clk);
      unit_acc_req <= r;
      @(posedge core_clk);
      unit_acc_req <= 2'h0;
      #1;
      `CHK(unit_acc_fault, f)
      `CHK(unit_acc_done, r & ~f)
   endtask : acc

   task automatic finish_test;
      if (bad_count == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test

   // Hang guard
   initial
   begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      finish_test();
   end

   // Main sequence
   initial
   begin
      srst = 1'b1;
      {reg_wr, reg_rd, sleep_req, deep_sleep_req} = 4'h0;
      reg_addr = 12'h0;
      reg_wdata = 32'h0;
      unit_acc_req = 2'h0;
      repeat (4) @(posedge core_clk);
      srst <= 1'b0;
      rd(SCG_OFS_SLP_GATE, 32'h0);
      rd(SCG_OFS_RUN_GATE, 32'h0);
      rd(SCG_OFS_RST_INFO, 32'h40);
      rd(12'h150, 32'h0);
      `CHK(unit_clk_en, 2'h0)
      wr(SCG_OFS_INT_MASK, 32'h7);
      acc(2'h3, 2'h3);
      tick(1);
      `CHK(irq, 1'b1)
      rd(SCG_OFS_INT_STAT, 32'h3);
      `CHK(irq, 1'b0)
      wr(SCG_OFS_SLP_GATE, 32'hFFFFFFFF);
      rd(SCG_OFS_SLP_GATE, 32'h00010308);
      wr_rd(SCG_OFS_SLP_GATE, 32'hFFFFFFFF, 32'h00010308);
      wr(SCG_OFS_RUN_GATE, 32'h00010000);
      tick(2);
      `CHK(unit_clk_en, 2'h1)
      acc(2'h3, 2'h2);
      rd(SCG_OFS_INT_STAT, 32'h2);
      // Sleep without automatic gating keeps the run word
      @(posedge core_clk);
      sleep_req <= 1'b1;
      tick(3);
      `CHK(unit_clk_en, 2'h1)
      rd(SCG_OFS_INT_STAT, 32'h4);
      wr(SCG_OFS_RUN_CFG, 32'h1);
      tick(2);
      `CHK(unit_clk_en, 2'h3)
      `CHK(unit_gclk, 2'h3)
      `CHK(converter_sample_rate, 2'h3)
      // Every sample rate code through the sleep word
      for (k = 0; k < 4; k++)
      begin
         wr(SCG_OFS_SLP_GATE, (32'(k) << 8) | 32'h8);
         tick(2);
         `CHK(converter_sample_rate, 2'(k))
         `CHK(unit_clk_en, 2'h2)
      end
      @(posedge core_clk);
      sleep_req <= 1'b0;
      tick(3);
      `CHK(unit_clk_en, 2'h1)
      `CHK(converter_sample_rate, 2'h0)
      @(posedge core_clk);
      deep_sleep_req <= 1'b1;
      tick(3);
      `CHK(unit_clk_en, 2'h0)
      `CHK(unit_gclk, 2'h0)
      rd(SCG_OFS_MODE_STAT, 32'h2);
      rd(SCG_OFS_INT_STAT, 32'h4);
      // Masked event leaves the output low
      wr(SCG_OFS_INT_MASK, 32'h0);
      acc(2'h1, 2'h1);
      tick(1);
      `CHK(irq, 1'b0)
      wr(SCG_OFS_INT_MASK, 32'h1);
      tick(1);
      `CHK(irq, 1'b1)
      rd(SCG_OFS_INT_STAT, 32'h1);
      `CHK(irq, 1'b0)
      finish_test();
   end
endmodule : scg_ctrl_bench
